/* File: core/synth_regs_pkg.sv */
//
// Purpose: shared constants for the synthesizer and serializer config bank
// Assumes: one-bit read flag, address and data words on the serial port
// Notes:   offsets, field positions, reset values and decodes live here
//
package synth_regs_pkg;

    // ****************************************************************
    // serial frame
    // ****************************************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 5;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFF_FBDIV_VP = 15'h003d;
    localparam logic [ADDR_W-1:0] OFF_FBDIV_N = 15'h003e;
    localparam logic [ADDR_W-1:0] OFF_OSC_BIAS = 15'h003f;
    localparam logic [ADDR_W-1:0] OFF_PREEMPH = 15'h0048;
    localparam logic [ADDR_W-1:0] OFF_TRIG_CTRL = 15'h0057;

    localparam int IDX_FBDIV_VP = 0;
    localparam int IDX_FBDIV_N = 1;
    localparam int IDX_OSC_BIAS = 2;
    localparam int IDX_PREEMPH = 3;
    localparam int IDX_TRIG_CTRL = 4;

    localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{
        OFF_FBDIV_VP, OFF_FBDIV_N, OFF_OSC_BIAS, OFF_PREEMPH, OFF_TRIG_CTRL};
    localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
        8'h00, 8'h20, 8'h4f, 8'h00, 8'h00};
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int V_LSB = 0;
    localparam int V_MSB = 1;
    localparam int P_LSB = 2;
    localparam int P_MSB = 3;
    localparam int N_LSB = 0;
    localparam int N_MSB = 5;
    localparam int BIAS_LSB = 0;
    localparam int BIAS_MSB = 6;
    localparam int PE_LSB = 0;
    localparam int PE_MSB = 3;
    localparam int TMODE_LSB = 0;
    localparam int TMODE_MSB = 2;
    localparam int TEN_BIT = 7;

    // ****************************************************************
    // field decodes
    // ****************************************************************
    localparam logic [1:0] V_CODE_DIV5 = 2'h0;
    localparam logic [1:0] V_CODE_DIV4 = 2'h1;
    localparam logic [1:0] V_CODE_DIV3 = 2'h2;
    localparam logic [1:0] P_CODE_DIV1 = 2'h0;
    localparam logic [1:0] P_CODE_DIV2 = 2'h1;
    localparam logic [1:0] P_CODE_DIV4 = 2'h2;
    localparam logic [2:0] RATIO_1 = 3'h1;
    localparam logic [2:0] RATIO_2 = 3'h2;
    localparam logic [2:0] RATIO_3 = 3'h3;
    localparam logic [2:0] RATIO_4 = 3'h4;
    localparam logic [2:0] RATIO_5 = 3'h5;
    localparam logic [2:0] RATIO_NONE = 3'h0;

    localparam logic [2:0] TMODE_UI16 = 3'h0;
    localparam logic [2:0] TMODE_UI32 = 3'h1;
    localparam logic [2:0] TMODE_UI64 = 3'h2;
    localparam logic [2:0] TMODE_TSTAMP = 3'h3;
    localparam logic [6:0] TDIV_16 = 7'h10;
    localparam logic [6:0] TDIV_32 = 7'h20;
    localparam logic [6:0] TDIV_64 = 7'h40;
    localparam logic [6:0] TDIV_OFF = 7'h00;

endpackage : synth_regs_pkg

/* File: core/serial_frame_port.sv */
//
// Purpose: serial control port framing: read flag, address, data
// Assumes: sclk and sdi synchronous to clk and far slower than it
// Notes:   msb first; host samples sdo on sclk rising edges
//
`timescale 1ns/1ps
module serial_frame_port #(
    parameter int ADDR_W = 15,
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // register side
    input wire logic [DATA_W-1:0] rd_data,
    output logic rd_req,
    output logic wr_stb,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wr_data
);

    localparam int CW = $clog2(ADDR_W + 2);
    localparam logic [CW-1:0] HDR_LAST = CW'(ADDR_W);
    localparam logic [CW-1:0] DAT_LAST = CW'(DATA_W - 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    typedef enum logic [1:0] {PH_HEADER, PH_DATA, PH_DONE} phase_t;

    phase_t phase_q;
    logic sclk_prev_q;
    logic [CW-1:0] cnt_q;
    logic [ADDR_W:0] hdr_q;
    logic [DATA_W-1:0] din_q;
    logic [DATA_W-1:0] dout_q;
    logic rw_q;
    logic load_q;
    logic rise;
    logic [ADDR_W:0] hdr_d;
    logic [DATA_W-1:0] din_d;

    assign rise = sclk & ~sclk_prev_q;
    assign hdr_d = {hdr_q[ADDR_W-1:0], sdi};
    assign din_d = {din_q[DATA_W-2:0], sdi};

    always_ff @(posedge clk) begin
        if (srst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk;
        end
    end

    // ****************************************************************
    // frame sequencing
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst || cs_n) begin
            phase_q <= PH_HEADER;
            cnt_q <= '0;
            hdr_q <= '0;
            din_q <= '0;
            rd_req <= 1'b0;
            wr_stb <= 1'b0;
        end else begin
            rd_req <= 1'b0;
            wr_stb <= 1'b0;
            if (rise) begin
                unique case (phase_q)
                    PH_HEADER: begin
                        hdr_q <= hdr_d;
                        cnt_q <= cnt_q + CNT_ONE;
                        if (cnt_q == HDR_LAST) begin
                            phase_q <= PH_DATA;
                            cnt_q <= '0;
                            rd_req <= hdr_d[ADDR_W];
                        end
                    end
                    PH_DATA: begin
                        din_q <= din_d;
                        cnt_q <= cnt_q + CNT_ONE;
                        if (cnt_q == DAT_LAST) begin
                            phase_q <= PH_DONE;
                            wr_stb <= ~rw_q;
                        end
                    end
                    PH_DONE: begin
                        phase_q <= PH_DONE;
                    end
                endcase
            end
        end
    end

    // address, direction and write word hold until the next frame
    always_ff @(posedge clk) begin
        if (srst) begin
            addr <= '0;
            rw_q <= 1'b0;
            wr_data <= '0;
        end else begin
            if (!cs_n && rise && phase_q == PH_HEADER && cnt_q == HDR_LAST)
            begin
                addr <= hdr_d[ADDR_W-1:0];
                rw_q <= hdr_d[ADDR_W];
            end
            if (!cs_n && rise && phase_q == PH_DATA && cnt_q == DAT_LAST)
            begin
                wr_data <= din_d;
            end
        end
    end

    // ****************************************************************
    // read data out
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            load_q <= 1'b0;
            dout_q <= '0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            load_q <= rd_req;
            if (load_q) begin
                dout_q <= rd_data;
            end else if (!cs_n && rise && phase_q == PH_DATA) begin
                dout_q <= {dout_q[DATA_W-2:0], 1'b0};
            end
            sdo <= dout_q[DATA_W-1];
            sdo_oe <= ~cs_n & rw_q & (phase_q == PH_DATA);
        end
    end

endmodule : serial_frame_port

/* File: core/synth_divider_serdes_ctrl_regs.sv */
//
// Purpose: config bank for synthesizer dividers, oscillator bias,
//          lane pre-emphasis and the trigger output
// Assumes: serial control port pins synchronous to REF_CLK
// Notes:   decoded settings are registered one cycle after the bank
`timescale 1ns/1ps
module synth_divider_serdes_ctrl_regs #(
    parameter int LANES = 8
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // serial control port
    input wire logic SCS_N,
    input wire logic SCLK,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE,
    // synthesizer divider chain and oscillator bias
    output logic [2:0] SYNTH_V_RATIO,
    output logic [2:0] SYNTH_P_RATIO,
    output logic [5:0] SYNTH_N_RATIO,
    output logic [4:0] SYNTH_SAMPLE_DIV,
    output logic [10:0] SYNTH_FEEDBACK_DIV,
    output logic SYNTH_DIV_CODE_BAD,
    output logic [6:0] OSC_BIAS,
    // serializer
    output logic [LANES*4-1:0] LANE_PREEMPHASIS,
    // trigger output
    output logic TRIG_OUT_ENABLE,
    output logic [6:0] TRIG_DIV_RATIO,
    output logic TRIG_TIMESTAMP_SEL,
    output logic TRIG_MODE_BAD
);

    localparam int NR = synth_regs_pkg::NUM_REGS;
    localparam int AW = synth_regs_pkg::ADDR_W;
    localparam int DW = synth_regs_pkg::DATA_W;

    logic rd_req;
    logic wr_stb;
    logic [AW-1:0] addr;
    logic [DW-1:0] wr_data;
    logic [DW-1:0] rd_data_q;
    logic [DW-1:0] regs_q [NR];
    logic [DW-1:0] rd_data_d;

    // ****************************************************************
    // serial port
    // ****************************************************************
    serial_frame_port #(
        .ADDR_W(AW),
        .DATA_W(DW)
    ) u_port (
        .clk(REF_CLK),
        .srst(SRST),
        .cs_n(SCS_N),
        .sclk(SCLK),
        .sdi(SDI),
        .sdo(SDO),
        .sdo_oe(SDO_OE),
        .rd_data(rd_data_q),
        .rd_req(rd_req),
        .wr_stb(wr_stb),
        .addr(addr),
        .wr_data(wr_data)
    );

    // ****************************************************************
    // register bank
    // ****************************************************************
    // the whole byte is stored so reserved bits read back as written;
    // keeping them zero is left to the host
    for (genvar i = 0; i < NR; i++) begin : g_reg
        always_ff @(posedge REF_CLK) begin
            if (SRST) begin
                regs_q[i] <= synth_regs_pkg::REG_RESET[i];
            end else if (wr_stb && addr == synth_regs_pkg::REG_OFFSET[i])
            begin
                regs_q[i] <= wr_data;
            end
        end
    end

    always_comb begin
        rd_data_d = synth_regs_pkg::UNMAPPED_READ;
        for (int i = 0; i < NR; i++) begin
            if (addr == synth_regs_pkg::REG_OFFSET[i]) begin
                rd_data_d = regs_q[i];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rd_data_q <= synth_regs_pkg::UNMAPPED_READ;
        end else if (rd_req) begin
            rd_data_q <= rd_data_d;
        end
    end

    // ****************************************************************
    // divider chain decode and oscillator bias
    // ****************************************************************
    logic [1:0] v_code;
    logic [1:0] p_code;
    logic [2:0] v_ratio_d;
    logic [2:0] p_ratio_d;
    logic [5:0] n_ratio_d;
    logic [4:0] sample_div_d;

    assign v_code = regs_q[synth_regs_pkg::IDX_FBDIV_VP]
        [synth_regs_pkg::V_MSB:synth_regs_pkg::V_LSB];
    assign p_code = regs_q[synth_regs_pkg::IDX_FBDIV_VP]
        [synth_regs_pkg::P_MSB:synth_regs_pkg::P_LSB];
    assign n_ratio_d = regs_q[synth_regs_pkg::IDX_FBDIV_N]
        [synth_regs_pkg::N_MSB:synth_regs_pkg::N_LSB];

    always_comb begin
        unique case (v_code)
            synth_regs_pkg::V_CODE_DIV5: v_ratio_d = synth_regs_pkg::RATIO_5;
            synth_regs_pkg::V_CODE_DIV4: v_ratio_d = synth_regs_pkg::RATIO_4;
            synth_regs_pkg::V_CODE_DIV3: v_ratio_d = synth_regs_pkg::RATIO_3;
            default: v_ratio_d = synth_regs_pkg::RATIO_NONE;
        endcase
        unique case (p_code)
            synth_regs_pkg::P_CODE_DIV1: p_ratio_d = synth_regs_pkg::RATIO_1;
            synth_regs_pkg::P_CODE_DIV2: p_ratio_d = synth_regs_pkg::RATIO_2;
            synth_regs_pkg::P_CODE_DIV4: p_ratio_d = synth_regs_pkg::RATIO_4;
            default: p_ratio_d = synth_regs_pkg::RATIO_NONE;
        endcase
    end

    // first divider feeds the second, whose output is the sampling clock
    assign sample_div_d = 5'(v_ratio_d * p_ratio_d);

    // a reserved code zeroes the ratio so it cannot pass for a real one;
    // a zero third-divider ratio is flagged the same way
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            SYNTH_V_RATIO <= synth_regs_pkg::RATIO_NONE;
            SYNTH_P_RATIO <= synth_regs_pkg::RATIO_NONE;
            SYNTH_N_RATIO <= '0;
            SYNTH_SAMPLE_DIV <= '0;
            SYNTH_FEEDBACK_DIV <= '0;
            SYNTH_DIV_CODE_BAD <= 1'b0;
        end else begin
            SYNTH_V_RATIO <= v_ratio_d;
            SYNTH_P_RATIO <= p_ratio_d;
            SYNTH_N_RATIO <= n_ratio_d;
            SYNTH_SAMPLE_DIV <= sample_div_d;
            SYNTH_FEEDBACK_DIV <= 11'(sample_div_d * n_ratio_d);
            SYNTH_DIV_CODE_BAD <= (v_ratio_d == synth_regs_pkg::RATIO_NONE)
                || (p_ratio_d == synth_regs_pkg::RATIO_NONE)
                || (n_ratio_d == '0);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            OSC_BIAS <= '0;
        end else begin
            OSC_BIAS <= regs_q[synth_regs_pkg::IDX_OSC_BIAS]
                [synth_regs_pkg::BIAS_MSB:synth_regs_pkg::BIAS_LSB];
        end
    end

    // ****************************************************************
    // lane pre-emphasis
    // ****************************************************************
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_ff @(posedge REF_CLK) begin
            if (SRST) begin
                LANE_PREEMPHASIS[l*4 +: 4] <= '0;
            end else begin
                LANE_PREEMPHASIS[l*4 +: 4] <=
                    regs_q[synth_regs_pkg::IDX_PREEMPH]
                    [synth_regs_pkg::PE_MSB:synth_regs_pkg::PE_LSB];
            end
        end
    end

    // ****************************************************************
    // trigger output
    // ****************************************************************
    logic trig_en;
    logic [2:0] trig_mode;

    assign trig_en = regs_q[synth_regs_pkg::IDX_TRIG_CTRL]
        [synth_regs_pkg::TEN_BIT];
    assign trig_mode = regs_q[synth_regs_pkg::IDX_TRIG_CTRL]
        [synth_regs_pkg::TMODE_MSB:synth_regs_pkg::TMODE_LSB];

    // divider and timestamp path are held off while the enable is low
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            TRIG_OUT_ENABLE <= 1'b0;
            TRIG_DIV_RATIO <= synth_regs_pkg::TDIV_OFF;
            TRIG_TIMESTAMP_SEL <= 1'b0;
            TRIG_MODE_BAD <= 1'b0;
        end else begin
            TRIG_OUT_ENABLE <= trig_en;
            TRIG_MODE_BAD <= trig_mode > synth_regs_pkg::TMODE_TSTAMP;
            TRIG_TIMESTAMP_SEL <= trig_en
                && trig_mode == synth_regs_pkg::TMODE_TSTAMP;
            if (!trig_en) begin
                TRIG_DIV_RATIO <= synth_regs_pkg::TDIV_OFF;
            end else begin
                unique case (trig_mode)
                    synth_regs_pkg::TMODE_UI16:
                        TRIG_DIV_RATIO <= synth_regs_pkg::TDIV_16;
                    synth_regs_pkg::TMODE_UI32:
                        TRIG_DIV_RATIO <= synth_regs_pkg::TDIV_32;
                    synth_regs_pkg::TMODE_UI64:
                        TRIG_DIV_RATIO <= synth_regs_pkg::TDIV_64;
                    default:
                        TRIG_DIV_RATIO <= synth_regs_pkg::TDIV_OFF;
                endcase
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_vp_write;
        wr_stb && addr == synth_regs_pkg::OFF_FBDIV_VP;
    endsequence

    property p_p_div4;
        @(posedge REF_CLK) disable iff (SRST)
        s_vp_write ##0 (wr_data[3:2] == 2'h2) |-> ##2 SYNTH_P_RATIO == 3'h4;
    endproperty
    a_p_div4: assert property (p_p_div4)
        else $error("second divider code 2 not decoded as 4");
    property p_v_div5;
        @(posedge REF_CLK) disable iff (SRST)
        s_vp_write ##0 (wr_data[1:0] == 2'h0) |-> ##2 SYNTH_V_RATIO == 3'h5;
    endproperty
    a_v_div5: assert property (p_v_div5)
        else $error("first divider code 0 not decoded as 5");
    property p_n_direct;
        @(posedge REF_CLK) disable iff (SRST)
        (wr_stb && addr == synth_regs_pkg::OFF_FBDIV_N)
            |-> ##2 SYNTH_N_RATIO == $past(wr_data[5:0], 2);
    endproperty
    a_n_direct: assert property (p_n_direct)
        else $error("third divider ratio differs from written value");
    property p_chain;
        @(posedge REF_CLK) disable iff (SRST)
        SYNTH_FEEDBACK_DIV == 11'(SYNTH_SAMPLE_DIV * SYNTH_N_RATIO)
            && SYNTH_SAMPLE_DIV == 5'(SYNTH_V_RATIO * SYNTH_P_RATIO);
    endproperty
    a_chain: assert property (p_chain)
        else $error("divider chain products inconsistent");
    property p_lanes_equal;
        @(posedge REF_CLK) disable iff (SRST)
        LANE_PREEMPHASIS == {LANES{LANE_PREEMPHASIS[3:0]}};
    endproperty
    a_lanes_equal: assert property (p_lanes_equal)
        else $error("lanes carry different pre-emphasis");
    property p_trig_off;
        @(posedge REF_CLK) disable iff (SRST)
        !TRIG_OUT_ENABLE |-> TRIG_DIV_RATIO == 7'h00 && !TRIG_TIMESTAMP_SEL;
    endproperty
    a_trig_off: assert property (p_trig_off)
        else $error("trigger path active while disabled");
    property p_trig_32;
        @(posedge REF_CLK) disable iff (SRST)
        (wr_stb && addr == synth_regs_pkg::OFF_TRIG_CTRL
            && wr_data == 8'h81) |-> ##2 TRIG_DIV_RATIO == 7'h20;
    endproperty
    a_trig_32: assert property (p_trig_32)
        else $error("trigger mode 1 not a 32 UI clock");
    property p_trig_field;
        @(posedge REF_CLK) disable iff (SRST)
        (wr_stb && addr == synth_regs_pkg::OFF_TRIG_CTRL
            && wr_data == 8'h83) |-> ##2 TRIG_TIMESTAMP_SEL
            && TRIG_OUT_ENABLE;
    endproperty
    a_trig_field: assert property (p_trig_field)
        else $error("mode field in control register not honoured");
    property p_readback;
        @(posedge REF_CLK) disable iff (SRST)
        (rd_req && addr == synth_regs_pkg::OFF_OSC_BIAS)
            |=> rd_data_q[6:0] == $past(OSC_BIAS);
    endproperty
    a_readback: assert property (p_readback)
        else $error("read does not return last written value");

endmodule : synth_divider_serdes_ctrl_regs

/* File: verification/serial_host_model.sv */
//
// Purpose: host side of the serial control port
// Assumes: pins change at the falling edge of REF_CLK
// Notes:   sdi idles at the inverse of its last bit
//
`timescale 1ns/1ps
module serial_host_model (
    // clock
    input wire logic REF_CLK,
    // serial pins
    output logic SCS_N,
    output logic SCLK,
    output logic SDI,
    input wire logic SDO,
    input wire logic SDO_OE
);
    // ****************************************************************
    // frame driver
    // ****************************************************************
    initial begin
        SCS_N = 1'b1;
        SCLK = 1'b0;
        SDI = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask : wait_n

    // each sclk phase lasts 3 cycles so the port sees every edge
    task automatic frame(input logic rd, input logic [14:0] addr,
                         input logic [7:0] wd, output logic [7:0] rdat);
        logic [23:0] vec;
        vec = {rd, addr, wd};
        rdat = 8'h00;
        @(negedge REF_CLK);
        SCS_N = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            SCLK = 1'b0;
            SDI = vec[i];
            wait_n(3);
            // read bits are taken just before the rise, as a real host;
            // an undriven bit reads unknown so a dead enable cannot pass
            if (i < 8) begin
                rdat[i] = (SDO_OE === 1'b1) ? SDO : 1'bx;
            end
            SCLK = 1'b1;
            wait_n(3);
        end
        SCLK = 1'b0;
        wait_n(3);
        SCS_N = 1'b1;
        SDI = ~SDI;
        wait_n(3);
    endtask : frame
endmodule : serial_host_model

/* File: verification/synth_divider_serdes_ctrl_regs_tb_top.sv */
//
// Purpose: self-checking bench for the synthesizer config bank
// Assumes: host model drives the serial port
// Notes:   expectations come from bench functions, package constants and literals
//
`timescale 1ns/1ps
module synth_divider_serdes_ctrl_regs_tb_top;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    logic clk, srst, cs_n, sclk, sdi, sdo, sdo_oe, en_o, ts, mbad, dbad;
    logic [2:0] v_o, p_o;
    logic [5:0] n_o, n;
    logic [4:0] samp;
    logic [10:0] fb;
    logic [6:0] bias, tdiv;
    logic [31:0] pe_o;
    logic [3:0] pe;
    int num_errors, total_checks, seed;

    serial_host_model i_serial_host_model (.REF_CLK(clk), .SCS_N(cs_n),
        .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe));

    synth_divider_serdes_ctrl_regs #(.LANES(8))
        i_synth_divider_serdes_ctrl_regs (.REF_CLK(clk), .SRST(srst),
        .SCS_N(cs_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe),
        .SYNTH_V_RATIO(v_o), .SYNTH_P_RATIO(p_o), .SYNTH_N_RATIO(n_o),
        .SYNTH_SAMPLE_DIV(samp), .SYNTH_FEEDBACK_DIV(fb),
        .SYNTH_DIV_CODE_BAD(dbad), .OSC_BIAS(bias),
        .LANE_PREEMPHASIS(pe_o), .TRIG_OUT_ENABLE(en_o),
        .TRIG_DIV_RATIO(tdiv), .TRIG_TIMESTAMP_SEL(ts),
        .TRIG_MODE_BAD(mbad));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_serial_host_model.frame(1'b0, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] r;
        i_serial_host_model.frame(1'b1, a, 8'h00, r);
        chk({24'h0, r}, {24'h0, e});
    endtask : rd_chk

    function automatic logic [2:0] exp_v(input logic [1:0] c);
        return (c == 2'h0) ? 3'h5 : (c == 2'h1) ? 3'h4 :
               (c == 2'h2) ? 3'h3 : 3'h0;
    endfunction : exp_v

    function automatic logic [2:0] exp_p(input logic [1:0] c);
        return (c == 2'h3) ? 3'h0 : 3'(1 << c);
    endfunction : exp_p

    task automatic chk_div(input logic [1:0] v, input logic [1:0] p,
                           input logic [5:0] nn);
        logic [10:0] prod;
        prod = 11'(exp_v(v) * exp_p(p));
        chk(v_o, exp_v(v));
        chk(p_o, exp_p(p));
        chk(n_o, nn);
        chk(samp, prod);
        chk(fb, 11'(prod * nn));
        chk(dbad, prod == 11'h0 || nn == 6'h0);
    endtask : chk_div

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        #500000;
        num_errors++;
        results();
    end

    initial begin
        seed = 32'h556c85d7;
        srst = 1'b1;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        for (int k = 0; k < synth_regs_pkg::NUM_REGS; k++) begin
            rd_chk(synth_regs_pkg::REG_OFFSET[k],
                   synth_regs_pkg::REG_RESET[k]);
        end
        chk_div(2'h0, 2'h0, 6'h20);
        chk(bias, 7'h4f);
        $display("test reset done");
        for (int k = 0; k < 16; k++) begin
            wr(synth_regs_pkg::OFF_FBDIV_VP, 8'(k));
            chk_div(2'(k), 2'(k >> 2), 6'h20);
        end
        wr(synth_regs_pkg::OFF_FBDIV_VP, 8'h06);
        for (int k = 0; k < 8; k++) begin
            n = (k == 0) ? 6'h01 : (k == 1) ? 6'h3f : 6'($random(seed));
            wr(synth_regs_pkg::OFF_FBDIV_N, {2'h0, n});
            chk_div(2'h2, 2'h1, n);
            rd_chk(synth_regs_pkg::OFF_FBDIV_N, {2'h0, n});
        end
        $display("test dividers done");
        wr(synth_regs_pkg::OFF_OSC_BIAS, 8'h4a);
        chk(bias, 7'h4a);
        rd_chk(synth_regs_pkg::OFF_OSC_BIAS, 8'h4a);
        for (int k = 0; k < 4; k++) begin
            pe = (k == 0) ? 4'hf : 4'($random(seed));
            wr(synth_regs_pkg::OFF_PREEMPH, {4'h0, pe});
            chk(pe_o, {8{pe}});
        end
        $display("test bias and lanes done");
        for (int m = 0; m < 8; m++) begin
            wr(synth_regs_pkg::OFF_TRIG_CTRL, 8'(m));
            chk({en_o, tdiv, ts}, 9'h0);
            wr(synth_regs_pkg::OFF_TRIG_CTRL, 8'(m) | 8'h80);
            chk(en_o, 1'b1);
            chk(tdiv, (m < 3) ? 7'(16 << m) : 7'h00);
            chk(ts, m == 3);
            chk(mbad, m > 3);
            wr(synth_regs_pkg::OFF_TRIG_CTRL, 8'(m));
        end
        $display("test trigger done");
        wr(15'h0040, 8'hff);
        rd_chk(15'h0040, synth_regs_pkg::UNMAPPED_READ);
        rd_chk(synth_regs_pkg::OFF_PREEMPH, {4'h0, pe});
        $display("test unmapped done");
        // a second reset must bring every written register back
        srst = 1'b1;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        repeat (2) @(negedge clk);
        for (int k = 0; k < synth_regs_pkg::NUM_REGS; k++) begin
            rd_chk(synth_regs_pkg::REG_OFFSET[k],
                   synth_regs_pkg::REG_RESET[k]);
        end
        chk_div(2'h0, 2'h0, 6'h20);
        chk(bias, 7'h4f);
        $display("test second reset done");
        results();
    end
endmodule : synth_divider_serdes_ctrl_regs_tb_top
